// ---- hdl/scg_fault_chk.sv ----
// Purpose: Flags accesses to units whose clock is off
// Assumes: One access request per cycle at most
// Notes: Fault pulse is one cycle, one clock after the request
`timescale 1ns/1ps
`default_nettype none
module scg_fault_chk
    import scg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire scg_pkg::scg_unit_t acc_unit,
    input wire logic [2:0] unit_en,
    output logic bus_fault,
    output logic bus_done,
    output logic [2:0] fault_evt
);
    logic gated_off;

    // Unit select code 3 is illegal and always faults
    always_comb
    begin
        unique case (acc_unit)
            UNIT_PWM: gated_off = !unit_en[0];
            UNIT_ADC: gated_off = !unit_en[1];
            UNIT_WDOG: gated_off = !unit_en[2];
            default: gated_off = 1'b1;
        endcase
    end

    // Exactly one of fault or done answers each access
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bus_fault <= 1'b0;
            bus_done <= 1'b0;
            fault_evt <= 3'h0;
        end
        else
        begin
            bus_fault <= acc_valid && gated_off;
            bus_done <= acc_valid && !gated_off;
            fault_evt <= 3'h0;
            if (acc_valid && gated_off && acc_unit != 2'b11)
                fault_evt[acc_unit] <= 1'b1;
        end
    end
endmodule : scg_fault_chk
`default_nettype wire

// ---- hdl/scg_gate_sel.sv ----
// Purpose: Picks which gating word drives the unit clock enables
// Assumes: Gating words are already registered
// Notes: Result is registered, one cycle after the words change
`timescale 1ns/1ps
`default_nettype none
module scg_gate_sel
    import scg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sleep_mode,
    input wire logic auto_gate_select,
    input wire logic [31:0] run_word,
    input wire logic [31:0] sleep_word,
    output logic [2:0] unit_en
);
    logic [2:0] next_unit_en;

    // Sleep word only counts when auto gating is on
    always_comb
    begin
        if (sleep_mode && auto_gate_select)
            next_unit_en = gate_bits(sleep_word);
        else
            next_unit_en = gate_bits(run_word);
    end

    // Registered so enables never glitch
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            unit_en <= 3'h0;
        else
            unit_en <= next_unit_en;
    end
endmodule : scg_gate_sel
`default_nettype wire

// ---- hdl/scg_sleep_gate.sv ----
// Purpose: Sleep clock gating register with unit enables and fault flags
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Run gating word is mirrored here so sleep fallback is self-contained
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bit 20 enables the pulse-width modulator clock in Sleep when set.
// - Bit 16 enables the converter clock in Sleep when set.
// - Bit 3 enables the watchdog clock in Sleep when set.
// - An access to a unit whose clock is off gets a bus fault.
// - After reset the register reads 0x00000040 with all units unclocked.
// - The register sits at 0x110, 32 bits, only gate bits and rate field writable.
// - Bits 9:8 pick the converter rate: 2 is 500K, 1 is 250K, 0 is 125K.
// - Sleep gating applies only while auto gating is selected.
module scg_sleep_gate
    import scg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [scg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [scg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [scg_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic acc_valid,
    input wire scg_pkg::scg_unit_t acc_unit,
    output logic acc_fault,
    output logic acc_done,
    output logic pwm_clk_en,
    output logic adc_clk_en,
    output logic wdog_clk_en,
    output logic [1:0] adc_rate,
    output logic irq
);
    import scg_pkg::*;

    logic [31:0] sleep_gate_reg0;
    logic [31:0] run_gate_reg0;
    logic [31:0] gate_ctrl;
    logic [2:0] fault_stat;
    logic [2:0] fault_mask;
    logic [2:0] unit_en;
    logic [2:0] fault_evt;
    logic [31:0] next_rdata;
    logic wr_sleep;
    logic wr_run;

    assign wr_sleep = reg_wr && reg_addr == OFF_SLEEP_GATE;
    assign wr_run = reg_wr && reg_addr == OFF_RUN_GATE;

    // Gating words keep bit 6 and reserved bits fixed
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sleep_gate_reg0 <= GATE_RESET;
        else if (wr_sleep)
            sleep_gate_reg0 <= (reg_wdata & GATE_WR_MASK) | GATE_RESET;
    end

    // Run word mirror, same layout and reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            run_gate_reg0 <= GATE_RESET;
        else if (wr_run)
            run_gate_reg0 <= (reg_wdata & GATE_WR_MASK) | GATE_RESET;
    end

    // Auto gate selection bit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            gate_ctrl <= CTRL_RESET;
        else if (reg_wr && reg_addr == OFF_GATE_CTRL)
            gate_ctrl <= {31'h0, reg_wdata[BIT_AUTO_GATE]};
    end

    // Fault mask
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fault_mask <= FAULT_RESET;
        else if (reg_wr && reg_addr == OFF_FAULT_MASK)
            fault_mask <= reg_wdata[2:0];
    end

    // Sticky faults, a new event beats a write-one clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fault_stat <= FAULT_RESET;
        else if (reg_wr && reg_addr == OFF_FAULT_STAT)
            fault_stat <= (fault_stat & ~reg_wdata[2:0]) | fault_evt;
        else
            fault_stat <= fault_stat | fault_evt;
    end

    // Level interrupt from a flop
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(fault_stat & fault_mask);
    end

    // Read mux, unmapped offsets read zero
    always_comb
    begin
        unique case (reg_addr)
            OFF_SLEEP_GATE: next_rdata = sleep_gate_reg0;
            OFF_RUN_GATE: next_rdata = run_gate_reg0;
            OFF_GATE_CTRL: next_rdata = gate_ctrl;
            OFF_FAULT_STAT: next_rdata = {29'h0, fault_stat};
            OFF_FAULT_MASK: next_rdata = {29'h0, fault_mask};
            default: next_rdata = 32'h0;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= 32'h0;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 32'h0;
    end

    // Enable selection
    scg_gate_sel u_sel
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .sleep_mode(sleep_mode),
        .auto_gate_select(gate_ctrl[BIT_AUTO_GATE]),
        .run_word(run_gate_reg0),
        .sleep_word(sleep_gate_reg0),
        .unit_en(unit_en)
    );

    assign pwm_clk_en = unit_en[0];
    assign adc_clk_en = unit_en[1];
    assign wdog_clk_en = unit_en[2];

    // Active word's rate field, registered; no clamping against the part limit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            adc_rate <= RATE_125K;
        else if (sleep_mode && gate_ctrl[BIT_AUTO_GATE])
            adc_rate <= sleep_gate_reg0[RATE_HI:RATE_LO];
        else
            adc_rate <= run_gate_reg0[RATE_HI:RATE_LO];
    end

    // Fault checker against the enables actually applied
    scg_fault_chk u_chk
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .acc_valid(acc_valid),
        .acc_unit(acc_unit),
        .unit_en(unit_en),
        .bus_fault(acc_fault),
        .bus_done(acc_done),
        .fault_evt(fault_evt)
    );

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_reset_value: assert property ($fell(rst) |-> sleep_gate_reg0 == 32'h0000_0040 && unit_en == 3'h0)
        else $error("gating word wrong after reset");
    a_reserved_fixed: assert property ((sleep_gate_reg0 & ~32'h0011_0308) == 32'h0000_0040)
        else $error("reserved bits of sleep word changed");
    a_sleep_write: assert property (reg_wr && reg_addr == 12'h110
        |=> sleep_gate_reg0[20] == $past(reg_wdata[20]) && sleep_gate_reg0[9:8] == $past(reg_wdata[9:8]))
        else $error("sleep word write not stored");
    a_pwm_sleep: assert property (sleep_mode && gate_ctrl[0] |=> pwm_clk_en == $past(sleep_gate_reg0[20]))
        else $error("pwm enable not from sleep word");
    a_adc_sleep: assert property (sleep_mode && gate_ctrl[0] |=> adc_clk_en == $past(sleep_gate_reg0[16]))
        else $error("converter enable not from sleep word");
    a_wdog_sleep: assert property (sleep_mode && gate_ctrl[0] |=> wdog_clk_en == $past(sleep_gate_reg0[3]))
        else $error("watchdog enable not from sleep word");
    a_run_fallback: assert property (!(sleep_mode && gate_ctrl[0])
        |=> unit_en == {$past(run_gate_reg0[3]), $past(run_gate_reg0[16]), $past(run_gate_reg0[20])})
        else $error("run word not applied");
    a_rate_sleep: assert property (sleep_mode && gate_ctrl[0] |=> adc_rate == $past(sleep_gate_reg0[9:8]))
        else $error("rate field not applied");
    a_fault_off: assert property (acc_valid && acc_unit == UNIT_PWM && !pwm_clk_en |=> acc_fault && !acc_done)
        else $error("access to stopped unit not faulted");
    a_fault_on: assert property (acc_valid && acc_unit == UNIT_ADC && adc_clk_en |=> acc_done && !acc_fault)
        else $error("access to running unit faulted");
    a_fault_sticky: assert property (acc_fault && $past(acc_unit) == UNIT_WDOG |=> fault_stat[2])
        else $error("fault not recorded");
    a_read_once: assert property (reg_rd ##1 !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data held too long");
    a_rate_run: assert property (!(sleep_mode && gate_ctrl[0]) |=> adc_rate == $past(run_gate_reg0[9:8]))
        else $error("rate field not from run word");
    a_one_answer: assert property (!(acc_fault && acc_done))
        else $error("access answered twice");
    a_irq_follow: assert property (|(fault_stat & fault_mask) |=> irq)
        else $error("interrupt not raised");

    c_sleep_auto: cover property (sleep_mode && gate_ctrl[0] ##1 pwm_clk_en);
    c_fault_irq: cover property (acc_fault ##[1:3] irq);
    c_clear_race: cover property (reg_wr && reg_addr == 12'h1f4 && fault_evt != 3'h0);
    c_rate_fast: cover property (adc_rate == RATE_500K);
endmodule : scg_sleep_gate
`default_nettype wire

// ---- shared/scg_pkg.sv ----
// Purpose: Shared constants for the sleep clock gating block
// Assumes: 32-bit register port, byte offsets as printed
// Notes: Field positions and resets are fixed by the register map
package scg_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_UNITS = 3;
    // Register offsets
    localparam logic [11:0] OFF_RUN_GATE = 12'h100;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
    localparam logic [11:0] OFF_GATE_CTRL = 12'h1f0;
    localparam logic [11:0] OFF_FAULT_STAT = 12'h1f4;
    localparam logic [11:0] OFF_FAULT_MASK = 12'h1f8;
    // Gating register layout
    localparam int unsigned BIT_PWM = 20;
    localparam int unsigned BIT_ADC = 16;
    localparam int unsigned BIT_WDOG = 3;
    localparam int unsigned RATE_LO = 8;
    localparam int unsigned RATE_HI = 9;
    localparam logic [31:0] GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] GATE_WR_MASK = 32'h0011_0308;
    // Control register layout
    localparam int unsigned BIT_AUTO_GATE = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0] FAULT_RESET = 3'h0;
    // Sample rate codes
    localparam logic [1:0] RATE_500K = 2'h2;
    localparam logic [1:0] RATE_250K = 2'h1;
    localparam logic [1:0] RATE_125K = 2'h0;
    // Unit select codes, also status bit index
    typedef enum logic [1:0]
    {
        UNIT_PWM = 2'b00,
        UNIT_ADC = 2'b01,
        UNIT_WDOG = 2'b10
    } scg_unit_t;

    // Extract the three unit enables from a gating word
    function automatic logic [2:0] gate_bits(input logic [31:0] w);
        gate_bits = {w[BIT_WDOG], w[BIT_ADC], w[BIT_PWM]};
    endfunction : gate_bits
endpackage : scg_pkg

// ---- tb/scg_sleep_gate_tb_top.sv ----
// Purpose: Self-checking bench for the sleep clock gating block
// Assumes: Register and access timing as handed over, one clock
// Notes: Random words come from a 16-bit shift register seeded with 91
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
        fail_count++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
end
module scg_sleep_gate_tb_top;
    import scg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic sleep_mode = 1'b0;
    logic acc_valid = 1'b0;
    scg_unit_t acc_unit = UNIT_PWM;
    logic acc_fault;
    logic acc_done;
    logic pwm_clk_en;
    logic adc_clk_en;
    logic wdog_clk_en;
    logic [1:0] adc_rate;
    logic irq;
    int fail_count = 0;
    int tests_run = 0;
    logic [15:0] lfsr = 16'h005b;
    logic [31:0] run_w;
    logic [31:0] slp_w;
    logic [31:0] act_w;
    logic [31:0] rd_v;
    logic au;
    logic sm;

    // 20 ns clock
    always #10 sys_clk = ~sys_clk;

    scg_sleep_gate dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
        .acc_valid(acc_valid), .acc_unit(acc_unit), .acc_fault(acc_fault), .acc_done(acc_done),
        .pwm_clk_en(pwm_clk_en), .adc_clk_en(adc_clk_en), .wdog_clk_en(wdog_clk_en),
        .adc_rate(adc_rate), .irq(irq)
    );

    // Rate code 3 is never drawn, software keeps within the part limit
    function automatic logic [31:0] rnd32();
        logic [31:0] v;
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        v[15:0] = lfsr;
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        v[31:16] = lfsr;
        v[9] = v[9] & ~v[8];
        return v;
    endfunction : rnd32

    // Word as stored: writable bits kept, bit 6 forced high
    function automatic logic [31:0] stored(input logic [31:0] w);
        return (w & 32'h0011_0308) | 32'h0000_0040;
    endfunction : stored

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, ex, reg_rdata)
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic acc(input scg_unit_t u, input logic ef);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_unit <= u;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        #1;
        `CHK("acc_fault", ef, acc_fault)
        `CHK("acc_done", ~ef, acc_done)
    endtask : acc

    task automatic chk_en(input logic [31:0] w);
        cyc(3);
        `CHK("pwm_clk_en", w[20], pwm_clk_en)
        `CHK("adc_clk_en", w[16], adc_clk_en)
        `CHK("wdog_clk_en", w[3], wdog_clk_en)
        `CHK("adc_rate", w[9:8], adc_rate)
    endtask : chk_en

    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        `CHK("pwm_clk_en", 1'b0, pwm_clk_en)
        rdchk("sleep reset", 12'h110, 32'h0000_0040);
        rdchk("run reset", 12'h100, 32'h0000_0040);
        rdchk("unmapped", 12'h114, 32'h0);
        wr(12'h114, 32'hffff_ffff);
        wr(12'h110, 32'hffff_feff);
        rdchk("ro bits", 12'h110, 32'h0011_0248);
        // Read-modify-write hands the read reserved bits back unchanged
        wr(12'h110, 32'h0001_0248);
        rdchk("rmw keep", 12'h110, 32'h0001_0248);
        // Random words, first three pin each rate code
        for (int i = 0; i < 40; i++)
        begin
            run_w = rnd32();
            slp_w = rnd32();
            if (i < 3)
                slp_w[9:8] = i[1:0];
            au = (i < 3) ? 1'b1 : lfsr[1];
            sm = (i < 3) ? 1'b1 : lfsr[2];
            wr(12'h100, run_w);
            wr(12'h110, slp_w);
            wr(12'h1f0, {31'h0, au});
            @(posedge sys_clk);
            sleep_mode <= sm;
            act_w = (sm && au) ? stored(slp_w) : stored(run_w);
            chk_en(act_w);
            acc(UNIT_PWM, ~act_w[20]);
            acc(UNIT_ADC, ~act_w[16]);
            acc(UNIT_WDOG, ~act_w[3]);
        end
        // Fault status, mask and level interrupt
        wr(12'h110, 32'h0);
        wr(12'h100, 32'h0);
        wr(12'h1f8, 32'h0);
        wr(12'h1f4, 32'h7);
        cyc(3);
        acc(UNIT_ADC, 1'b1);
        acc(scg_unit_t'(2'h3), 1'b1);
        cyc(2);
        `CHK("irq masked", 1'b0, irq)
        rdchk("fault status", 12'h1f4, 32'h2);
        wr(12'h1f8, 32'h2);
        cyc(2);
        `CHK("irq", 1'b1, irq)
        wr(12'h1f4, 32'h2);
        cyc(2);
        `CHK("irq cleared", 1'b0, irq)
        rdchk("status cleared", 12'h1f4, 32'h0);
        // Second reset mid-run
        wr(12'h110, 32'h0011_0308);
        @(posedge sys_clk);
        rst <= 1'b1;
        cyc(2);
        @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("sleep re-reset", 12'h110, 32'h0000_0040);
        `CHK("wdog re-reset", 1'b0, wdog_clk_en)
        wrap_up();
    end
endmodule : scg_sleep_gate_tb_top
`undef CHK
`default_nettype wire
